// ===== rtl/isrp_slave.sv
// Register port end: eight-byte array behind a two-wire slave.
// Assumes link_clk free-running and much faster than SCL;
// the bus itself carries all timing, link_clk only samples the lines.
module isrp_slave (
  input  wire logic  link_clk,            // Sampling clock
  input  wire logic  link_rst_b,          // Sync reset, active low
  input  wire logic  slave_addr_strap_lo, // Address bit 0 pin
  input  wire logic  slave_addr_strap_hi, // Address bit 1 pin
  isrp_if.slave      bus,                 // Two-wire bus
  output logic [isrp_pkg::NUM_REGS*isrp_pkg::BYTE_W-1:0] cfg_image, // Array
  output logic       function_powerdown_bit,  // Function shutdown field
  output logic       quiescent_powerdown_bit  // Quiescent shutdown field
);
  import isrp_pkg::*;

  if (NUM_REGS != (1 << PTR_W)) begin : g_chk
    $error("isrp_slave: pointer must wrap exactly at NUM_REGS");
  end

  // Filtered bus and straps
  logic       scl_f;     // Deglitched SCL
  logic       sda_f;     // Deglitched SDA
  logic [1:0] strap_f;   // Synchronised straps

  // Edge history
  logic       scl_p_q;   // SCL one sample ago
  logic       sda_p_q;   // SDA one sample ago

  // Protocol state
  isrp_sst_t         state_q;  // Transfer phase
  logic [3:0]        bit_q;    // SCL rises in this byte
  logic [BYTE_W-1:0] rx_q;     // Received byte
  logic [BYTE_W-1:0] tx_q;     // Byte being sent
  logic [PTR_W-1:0]  ptr_q;    // Register pointer
  logic              rw_q;     // Read requested
  logic              mack_q;   // Master acked last sent byte
  logic              oe_q;     // Pulling SDA low

  // Register array
  logic [BYTE_W-1:0] regs_q [NUM_REGS]; // Configuration bytes

  // Events
  logic start_ev;  // START seen
  logic stop_ev;   // STOP seen
  logic rise_ev;   // SCL rising
  logic fall_ev;   // SCL falling
  logic ack_pt;    // Fall after eighth bit
  logic end_pt;    // Fall after ack bit
  logic addr_hit;  // Address matches us
  logic wr_commit; // Commit a written byte
  logic load_rd;   // Load next read byte

  // Bus lines and straps cross into link_clk and are deglitched
  isrp_sync #(
    .W       (4),
    .FILT    (FILT_LEN),
    .RST_VAL (4'hC)
  ) u_sync (
    .clk   (link_clk),
    .rst_b (link_rst_b),
    .din   ({bus.scl, bus.sda, slave_addr_strap_hi, slave_addr_strap_lo}),
    .dout  ({scl_f, sda_f, strap_f})
  );

  // Remember previous filtered levels
  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
    end
  end

  // SDA moving under a high SCL is framing, never data
  assign start_ev = scl_f & scl_p_q & sda_p_q & ~sda_f;
  assign stop_ev  = scl_f & scl_p_q & ~sda_p_q & sda_f;
  // Data sampled on rise, driven on fall
  assign rise_ev  = scl_f & ~scl_p_q;
  assign fall_ev  = ~scl_f & scl_p_q;
  assign ack_pt   = fall_ev & (bit_q == BIT_ACK);
  assign end_pt   = fall_ev & (bit_q == BIT_END);
  // Seven-bit match: fixed prefix plus strap levels
  assign addr_hit = (rx_q[7:1] == {ADDR_PREFIX, strap_f});
  // Commit happens on the fall that starts our ack
  assign wr_commit = ack_pt & (state_q == S_WR);
  assign load_rd   = end_pt & (((state_q == S_ADDR) & rw_q) |
                               ((state_q == S_RD) & mack_q));

  // Count SCL pulses, one per bit, nine per byte
  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      bit_q <= 4'h0;
    end else if (start_ev || stop_ev) begin
      bit_q <= 4'h0;
    end else if (end_pt) begin
      bit_q <= 4'h0;
    end else if (rise_ev && bit_q < BIT_END) begin
      bit_q <= bit_q + 4'h1;
    end
  end

  // Shift in data bits, MSB first
  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      rx_q <= 8'h00;
    end else if (rise_ev && bit_q < BIT_ACK) begin
      rx_q <= {rx_q[6:0], sda_f};
    end
  end

  // Sample the master's answer on the ninth rise
  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      mack_q <= 1'b0;
    end else if (rise_ev && bit_q == BIT_ACK) begin
      mack_q <= ~sda_f;
    end
  end

  // Transfer phase; a START anywhere restarts address decode,
  // so a byte cut short never reaches the commit point
  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      state_q <= S_IDLE;
      rw_q    <= 1'b0;
    end else if (start_ev) begin
      state_q <= S_ADDR;
    end else if (stop_ev) begin
      state_q <= S_IDLE;
    end else if (ack_pt && state_q == S_ADDR) begin
      if (addr_hit) begin
        rw_q <= rx_q[0];
      end else begin
        state_q <= S_IDLE; // Not ours: ignore until next START
      end
    end else if (end_pt) begin
      unique case (state_q)
        S_ADDR:  state_q <= rw_q ? S_RD : S_REG;
        S_REG:   state_q <= S_WR;
        S_RD:    state_q <= mack_q ? S_RD : S_IDLE;
        S_WR:    state_q <= S_WR;
        S_IDLE:  state_q <= S_IDLE;
      endcase
    end
  end

  // Pointer: loaded by the register byte after the address, bumped per data byte;
  // untouched by restart so a following read starts there
  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      ptr_q <= 3'h0;
    end else if (ack_pt && state_q == S_REG) begin
      ptr_q <= rx_q[PTR_W-1:0];
    end else if (wr_commit) begin
      ptr_q <= ptr_q + 3'h1;
    end else if (load_rd) begin
      ptr_q <= ptr_q + 3'h1;
    end
  end

  // Outgoing byte shifter
  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      tx_q <= 8'h00;
    end else if (load_rd) begin
      tx_q <= regs_q[ptr_q];
    end else if (fall_ev && state_q == S_RD && bit_q < BIT_ACK) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // SDA drive, changed only on SCL falls so it is stable while high
  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      oe_q <= 1'b0;
    end else if (start_ev || stop_ev) begin
      oe_q <= 1'b0;
    end else if (ack_pt) begin
      // Ack whole ninth pulse when addressed and receiving
      unique case (state_q)
        S_ADDR:  oe_q <= addr_hit;
        S_REG:   oe_q <= 1'b1;
        S_WR:    oe_q <= 1'b1;
        S_RD:    oe_q <= 1'b0; // Master answers
        S_IDLE:  oe_q <= 1'b0;
      endcase
    end else if (load_rd) begin
      oe_q <= ~regs_q[ptr_q][7];
    end else if (end_pt) begin
      oe_q <= 1'b0;
    end else if (fall_ev && state_q == S_RD && bit_q < BIT_ACK && bit_q != 4'h0) begin
      oe_q <= ~tx_q[6];
    end
  end

  assign bus.sda_s_o  = 1'b0;
  assign bus.sda_s_oe = oe_q;

  // Array: clear at reset, written only at the ack point;
  // no field gates the port, so shutdown keeps access alive
  for (genvar r = 0; r < NUM_REGS; r++) begin : g_reg
    always_ff @(posedge link_clk) begin
      if (!link_rst_b) begin
        regs_q[r] <= REG_RST;
      end else if (wr_commit && ptr_q == PTR_W'(r)) begin
        regs_q[r] <= rx_q;
      end
    end
    assign cfg_image[r*BYTE_W +: BYTE_W] = regs_q[r];
  end

  // Shutdown fields are plain outputs, never fed back
  assign function_powerdown_bit  = regs_q[FPD_BYTE][FPD_BIT];
  assign quiescent_powerdown_bit = regs_q[QPD_BYTE][QPD_BIT];
endmodule

// ===== rtl/isrp_pkg.sv
// Constants and types for the two-wire register port and its master.
// Assumes both ends import this package; no other dependencies.
package isrp_pkg;
  // Master clock and SCL quarter period
  localparam int CLK_PERIOD_NS = 8;    // Master clock period
  localparam int SCL_QTR_NS    = 2000; // Least SCL quarter period
  localparam int SCL_QTR_CYC   = (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Register array shape
  localparam int NUM_REGS = 8;         // Bytes in the array
  localparam int PTR_W    = 3;         // Pointer width
  localparam int BYTE_W   = 8;         // Bits per register
  localparam logic [BYTE_W-1:0] REG_RST = 8'h00; // Reset value
  // Slave address upper bits
  localparam logic [4:0] ADDR_PREFIX = 5'h16;
  // Bit counter landmarks within a byte
  localparam logic [3:0] BIT_ACK = 4'h8; // Eight data bits seen
  localparam logic [3:0] BIT_END = 4'h9; // Ack clock seen
  // Powerdown field positions
  localparam int FPD_BYTE = 1;
  localparam int FPD_BIT  = 5;
  localparam int QPD_BYTE = 6;
  localparam int QPD_BIT  = 5;
  // Deglitch length in link clock samples
  localparam int FILT_LEN = 2;
  // Device protocol states
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_ADDR = 3'h1, S_REG = 3'h3, S_WR = 3'h2, S_RD = 3'h6
  } isrp_sst_t;
  // Master line states
  typedef enum logic [1:0] {
    M_IDLE = 2'h0, M_START = 2'h1, M_BIT = 2'h3, M_STOP = 2'h2
  } isrp_mst_t;
  // Master byte kinds
  typedef enum logic [2:0] {
    K_AW = 3'h0, K_REG = 3'h1, K_AR = 3'h3, K_WD = 3'h2, K_RD = 3'h6
  } isrp_kind_t;
endpackage

// ===== rtl/isrp_if.sv
// Two-wire bus joining the master end and the register port end.
// Assumes pull-ups: a line is low only while some party enables it.
interface isrp_if;
  logic scl_m_o;  // Master SCL value (always 0)
  logic scl_m_oe; // Master pulls SCL low
  logic sda_m_o;  // Master SDA value (always 0)
  logic sda_m_oe; // Master pulls SDA low
  logic sda_s_o;  // Device SDA value (always 0)
  logic sda_s_oe; // Device pulls SDA low
  logic scl;      // Resolved SCL level
  logic sda;      // Resolved SDA level
  // Wired-AND resolution of the open-drain lines
  assign scl = ~(scl_m_oe & ~scl_m_o);
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
  modport master (output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe, input scl, sda);
  modport slave  (output sda_s_o, sda_s_oe, input scl, sda);
endinterface

// ===== rtl/isrp_sync.sv
// Two-flop synchroniser with a per-bit deglitch filter.
// Assumes asynchronous inputs; output changes after FILT equal samples.
module isrp_sync #(
  parameter int           W       = 1,  // Bits carried
  parameter int           FILT    = 1,  // Samples a new level must hold
  parameter logic [W-1:0] RST_VAL = '0  // Output after reset
) (
  input  wire logic         clk,   // Sampling clock
  input  wire logic         rst_b, // Sync reset, active low
  input  wire logic [W-1:0] din,   // Asynchronous inputs
  output logic      [W-1:0] dout   // Filtered outputs
);
  if (FILT < 1 || FILT > 15) begin : g_chk
    $error("isrp_sync: FILT out of range");
  end
  logic [W-1:0] s1_q; // First stage, read only by s2_q
  logic [W-1:0] s2_q; // Second stage
  // Two-flop crossing
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
    end
  end
  // Deglitch each bit: a level must persist FILT samples
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic [3:0] run_q; // Samples differing from output
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        run_q   <= 4'h0;
        dout[i] <= RST_VAL[i];
      end else if (s2_q[i] == dout[i]) begin
        run_q <= 4'h0;
      end else if (run_q == 4'(FILT - 1)) begin
        run_q   <= 4'h0;
        dout[i] <= s2_q[i];
      end else begin
        run_q <= run_q + 4'h1;
      end
    end
  end
endmodule

// ===== rtl/isrp_master.sv
// Bus master end: runs register writes and reads on the two-wire bus.
// Assumes one command at a time; SCL is divided down from clk.
module isrp_master #(
  parameter int QTR_CYC = isrp_pkg::SCL_QTR_CYC, // Clocks per SCL quarter
  parameter int LEN_W   = 5                      // Byte count width
) (
  input  wire logic             clk,       // System clock
  input  wire logic             rst_b,     // Sync reset, active low
  input  wire logic             cmd_valid, // Command offered
  output logic                  cmd_ready, // Idle, command taken
  input  wire logic             cmd_read,  // 1 read, 0 write
  input  wire logic [1:0]       cmd_strap, // Device strap bits
  input  wire logic [isrp_pkg::PTR_W-1:0] cmd_reg, // Start register
  input  wire logic [LEN_W-1:0] cmd_len,   // Data bytes, 1 or more
  input  wire logic [7:0]       wr_data,   // Next write byte
  output logic                  wr_take,   // wr_data consumed
  output logic [7:0]            rd_data,   // Read byte
  output logic                  rd_valid,  // rd_data new
  output logic                  done,      // Transfer finished
  output logic                  done_nack, // Device did not ack
  isrp_if.master                bus        // Two-wire bus
);
  import isrp_pkg::*;

  if (QTR_CYC < 2 || QTR_CYC > 4096) begin : g_chk
    $error("isrp_master: QTR_CYC out of range");
  end

  logic [12:0]      div_q;  // Quarter divider
  logic [1:0]       qp_q;   // Quarter within phase
  isrp_mst_t        st_q;   // Line state
  isrp_kind_t       kind_q; // Byte in flight
  logic [8:0]       sh_q;   // Bits to send, ack slot last
  logic [7:0]       rx_q;   // Bits received
  logic [3:0]       bit_q;  // Bit in byte
  logic [LEN_W-1:0] cnt_q;  // Data bytes left
  logic             rd_q;   // Read command
  logic [1:0]       strap_q;// Target strap
  logic [PTR_W-1:0] reg_q;  // Target register
  logic             nak_q;  // Slave left ack high
  logic             scl_oe_q; // Pull SCL low
  logic             sda_oe_q; // Pull SDA low
  logic             sda_in;   // Synchronised SDA
  logic             tick;     // Quarter boundary
  logic             accept;   // Command taken

  // SDA comes back through a two-flop synchroniser on clk
  isrp_sync #(.W(1), .FILT(1), .RST_VAL(1'b1)) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .din   (bus.sda),
    .dout  (sda_in)
  );

  assign cmd_ready = (st_q == M_IDLE);
  assign accept    = cmd_valid & cmd_ready;
  assign tick      = (div_q == 13'h0);

  // Quarter-period timebase, realigned on each command
  always_ff @(posedge clk) begin
    if (!rst_b || accept || tick) begin
      div_q <= 13'(QTR_CYC - 1);
    end else begin
      div_q <= div_q - 13'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b || accept) begin
      qp_q <= 2'h0;
    end else if (tick) begin
      qp_q <= qp_q + 2'h1;
    end
  end

  // Line sequencer: START, nine-bit bytes, STOP
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q <= M_IDLE; kind_q <= K_AW; sh_q <= 9'h1FF; rx_q <= 8'h00;
      bit_q <= 4'h0; cnt_q <= '0; rd_q <= 1'b0; strap_q <= 2'h0;
      reg_q <= '0; nak_q <= 1'b0; scl_oe_q <= 1'b0; sda_oe_q <= 1'b0;
    end else if (accept) begin
      st_q <= M_START; kind_q <= K_AW; rd_q <= cmd_read; nak_q <= 1'b0;
      strap_q <= cmd_strap; reg_q <= cmd_reg; cnt_q <= cmd_len;
    end else if (tick) begin
      unique case (st_q)
        M_IDLE: ;
        M_START: begin // Also serves as repeated START
          unique case (qp_q)
            2'h0: sda_oe_q <= 1'b0;
            2'h1: scl_oe_q <= 1'b0;
            2'h2: sda_oe_q <= 1'b1;
            2'h3: begin
              scl_oe_q <= 1'b1; st_q <= M_BIT; bit_q <= 4'h0;
              sh_q <= {ADDR_PREFIX, strap_q, kind_q == K_AR, 1'b1};
            end
          endcase
        end
        M_BIT: begin // Change SDA only with SCL low
          unique case (qp_q)
            2'h0: sda_oe_q <= ~sh_q[8];
            2'h1: scl_oe_q <= 1'b0;
            2'h2: if (bit_q == BIT_ACK) nak_q <= sda_in;
                  else rx_q <= {rx_q[6:0], sda_in};
            2'h3: begin
              scl_oe_q <= 1'b1;
              bit_q    <= bit_q + 4'h1;
              sh_q     <= {sh_q[7:0], 1'b1};
              if (bit_q == BIT_ACK) begin // Ninth pulse done
                bit_q <= 4'h0;
                if (nak_q && kind_q != K_RD) begin
                  st_q <= M_STOP;
                end else unique case (kind_q)
                  K_AW: begin
                    kind_q <= K_REG; sh_q <= {5'h00, reg_q, 1'b1};
                  end
                  K_REG: if (rd_q) begin
                    kind_q <= K_AR; st_q <= M_START;
                  end else begin
                    kind_q <= K_WD; sh_q <= {wr_data, 1'b1};
                  end
                  K_AR: begin
                    kind_q <= K_RD; sh_q <= {8'hFF, cnt_q == LEN_W'(1)};
                  end
                  K_WD: if (cnt_q == LEN_W'(1)) st_q <= M_STOP;
                        else begin
                          cnt_q <= cnt_q - LEN_W'(1); sh_q <= {wr_data, 1'b1};
                        end
                  K_RD: if (cnt_q == LEN_W'(1)) st_q <= M_STOP;
                        else begin
                          cnt_q <= cnt_q - LEN_W'(1);
                          sh_q  <= {8'hFF, cnt_q == LEN_W'(2)};
                        end
                  default: st_q <= M_STOP;
                endcase
              end
            end
          endcase
        end
        M_STOP: begin // SDA rises under high SCL
          unique case (qp_q)
            2'h0: sda_oe_q <= 1'b1;
            2'h1: scl_oe_q <= 1'b0;
            2'h2: sda_oe_q <= 1'b0;
            2'h3: st_q <= M_IDLE;
          endcase
        end
      endcase
    end
  end

  // One-cycle user pulses tied to sequencer moments
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_take <= 1'b0; rd_valid <= 1'b0; rd_data <= 8'h00;
      done <= 1'b0; done_nack <= 1'b0;
    end else begin
      wr_take  <= 1'b0;
      rd_valid <= 1'b0;
      done     <= 1'b0;
      if (tick && st_q == M_BIT && qp_q == 2'h3 && bit_q == BIT_ACK) begin
        wr_take  <= ~nak_q & ((kind_q == K_REG & ~rd_q) |
                    (kind_q == K_WD & cnt_q != LEN_W'(1)));
        rd_valid <= (kind_q == K_RD);
        if (kind_q == K_RD) rd_data <= rx_q;
      end
      if (tick && st_q == M_STOP && qp_q == 2'h3) begin
        done      <= 1'b1;
        done_nack <= nak_q & (kind_q != K_RD);
      end
    end
  end

  assign bus.scl_m_o  = 1'b0;
  assign bus.scl_m_oe = scl_oe_q;
  assign bus.sda_m_o  = 1'b0;
  assign bus.sda_m_oe = sda_oe_q;
endmodule

// ===== tb/isrp_sva.sv
// Line checker for the two-wire bus between master end and register port.
// Assumes the bench top hands in both clocks, both resets and the bus signals.
module isrp_sva (
  input wire logic clk,        // Master clock
  input wire logic rst_b,      // Master reset, active low
  input wire logic link_clk,   // Port clock
  input wire logic link_rst_b, // Port reset, active low
  input wire logic scl_m_o,    // Master SCL value
  input wire logic scl_m_oe,   // Master SCL pull
  input wire logic sda_m_o,    // Master SDA value
  input wire logic sda_m_oe,   // Master SDA pull
  input wire logic sda_s_o,    // Port SDA value
  input wire logic sda_s_oe,   // Port SDA pull
  input wire logic scl,        // Resolved SCL
  input wire logic sda         // Resolved SDA
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       scl_q, sda_q; // Line levels one clock back
  logic       frame_q;      // Inside START..STOP
  logic [7:0] rise_q;       // SCL rises since last framing event
  wire start_ev = scl & scl_q & sda_q & ~sda; // SDA falls, SCL high
  wire stop_ev  = scl & scl_q & ~sda_q & sda; // SDA rises, SCL high
  // Line history; reset reads as an idle bus
  always_ff @(posedge clk) begin
    scl_q <= scl | ~rst_b;
    sda_q <= sda | ~rst_b;
  end
  // Frame tracking
  always_ff @(posedge clk) begin
    frame_q <= rst_b & (start_ev | (frame_q & ~stop_ev));
  end
  // Pulse count; restarts at every framing event
  always_ff @(posedge clk) begin
    if (!rst_b || start_ev || stop_ev) begin
      rise_q <= 8'h00;
    end else if (scl && !scl_q) begin
      rise_q <= rise_q + 8'h01;
    end
  end
  // Bounded wait for the end of an SCL high period
  sequence seq_scl_fall;
    ##[1:300] $fell(scl);
  endsequence
  a_master_odrain: assert property (@(posedge clk) disable iff (!rst_b)
    !scl_m_o && !sda_m_o) else $error("master drives a high level");
  a_port_sda_lowscl: assert property (@(posedge link_clk) disable iff (!link_rst_b)
    $changed(sda_s_oe) |-> !scl && !sda_s_o) else $error("port moved SDA while SCL high");
  a_master_sda_hold: assert property (@(posedge clk) disable iff (!rst_b)
    scl && $changed(sda_m_oe) |-> $past(scl, 16)) else $error("master moved SDA early");
  a_nine_pulses: assert property (@(posedge clk) disable iff (!rst_b)
    start_ev || stop_ev |-> rise_q == 8'h00 || rise_q % 9 == 1) else $error("pulse count");
  a_ack_full_high: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(scl) && sda_s_oe |-> sda_s_oe throughout seq_scl_fall) else $error("short ack");
  a_stop_released: assert property (@(posedge clk) disable iff (!rst_b)
    stop_ev |=> !sda_s_oe [*8]) else $error("port holds SDA after STOP");
  a_idle_after_rst: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(rst_b) |-> !scl_m_oe && !sda_m_oe) else $error("bus not idle after reset");
  a_clock_in_frame: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(scl_m_oe) |-> frame_q) else $error("SCL pulled outside a frame");
endmodule

// ===== tb/i2c_slave_register_port_test.sv
// Self-checking bench: master end and register port joined on one bus.
// Assumes the design package, interface and modules are compiled first.
module i2c_slave_register_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  import isrp_pkg::*;
  logic        clk, rst_b, link_clk, link_rst_b; // Clocks, resets
  logic        cmd_valid, cmd_ready, cmd_read;   // Command port
  logic [1:0]  cmd_strap, strap;                 // Target, pin levels
  logic [2:0]  cmd_reg;                          // Start register
  logic [4:0]  cmd_len;                          // Byte count
  logic [7:0]  wr_data, rd_data;                 // Data paths
  logic        wr_take, rd_valid, done, done_nack;
  logic        fpd, qpd;                         // Powerdown fields
  logic [63:0] cfg_image, e;                     // Port image, expected
  logic [7:0]  img[8], wdat[16];                 // Model, stimulus
  logic [7:0]  rd_q[$];                          // Notes: read bytes
  logic        nack_q[$];                        // Notes: ack status
  logic [63:0] img_q[$];                         // Notes: images
  int          miscompares = 0, comparisons = 0, widx = 0, k;
  int          seed = 32'h32a4941b;              // Fixed seed
  isrp_if isrp_if_i ();
  isrp_master #(.QTR_CYC(64), .LEN_W(5)) isrp_master_i (.clk(clk), .rst_b(rst_b),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_strap(cmd_strap),
    .cmd_reg(cmd_reg), .cmd_len(cmd_len), .wr_data(wr_data), .wr_take(wr_take),
    .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .done_nack(done_nack),
    .bus(isrp_if_i.master));
  isrp_slave isrp_slave_i (.link_clk(link_clk), .link_rst_b(link_rst_b),
    .slave_addr_strap_lo(strap[0]), .slave_addr_strap_hi(strap[1]), .bus(isrp_if_i.slave),
    .cfg_image(cfg_image), .function_powerdown_bit(fpd), .quiescent_powerdown_bit(qpd));
  isrp_sva isrp_sva_i (.clk(clk), .rst_b(rst_b), .link_clk(link_clk), .link_rst_b(link_rst_b),
    .scl_m_o(isrp_if_i.scl_m_o), .scl_m_oe(isrp_if_i.scl_m_oe), .sda_m_o(isrp_if_i.sda_m_o),
    .sda_m_oe(isrp_if_i.sda_m_oe), .sda_s_o(isrp_if_i.sda_s_o), .sda_s_oe(isrp_if_i.sda_s_oe),
    .scl(isrp_if_i.scl), .sda(isrp_if_i.sda));
  initial clk = 1'h0;
  always #4 clk = ~clk; // 125 MHz
  // Port clock, offset so its edges drift against clk
  initial begin
    link_clk = 1'h0;
    #3.3;
    forever #62.5 link_clk = ~link_clk;
  end
  // Count one comparison, report a mismatch
  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'h1) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Note the expected outcome, then run one command up to done
  task automatic xfer(input logic rd, input logic [1:0] st, input logic [2:0] r,
                      input logic [4:0] n);
    int          i;
    logic        hit;
    logic [63:0] x;
    hit = (st === strap);
    for (i = 0; i < n; i++) begin
      if (rd) begin
        rd_q.push_back(img[(r + i) % 8]);
      end else if (hit) begin
        img[(r + i) % 8] = wdat[i]; // Pointer wraps past the last register
      end
    end
    for (i = 0; i < 8; i++) begin
      x[8*i +: 8] = img[i];
    end
    nack_q.push_back(~hit);
    img_q.push_back(x);
    widx = 0;
    wr_data   <= wdat[0];
    cmd_read  <= rd;
    cmd_strap <= st;
    cmd_reg   <= r;
    cmd_len   <= n;
    cmd_valid <= 1'h1;
    @(posedge clk);
    cmd_valid <= 1'h0;
    @(posedge clk);
    check(cmd_ready === 1'h0, "command not taken");
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (done !== 1'h1 && i < 40000);
    check(i < 40000, "transfer never finished");
  endtask
  // Next write byte once the master has taken one
  always @(posedge clk) begin
    if (wr_take === 1'h1) begin
      widx = widx + 1;
      wr_data <= wdat[widx % 16];
    end
  end
  // Result watcher: oldest note against each result
  always @(posedge clk) begin
    if (rd_valid === 1'h1) begin
      check(rd_q.size() > 0 && rd_data === rd_q.pop_front(), "read byte");
    end
    if (done === 1'h1) begin
      e = img_q.pop_front();
      check(done_nack === nack_q.pop_front(), "ack status");
      check(cfg_image === e, "register image");
      check({fpd, qpd} === {e[13], e[53]}, "powerdown fields");
    end
  end
  // Hang guard, past the expected run of about 85,000 clocks
  initial begin
    #780000;
    miscompares++;
    conclude();
  end
  // Reset, then the scenarios
  initial begin
    rst_b = 1'h0;
    link_rst_b = 1'h0;
    cmd_valid = 1'h0;
    cmd_read = 1'h0;
    cmd_strap = 2'h0;
    cmd_reg = 3'h0;
    cmd_len = 5'h01;
    wr_data = 8'h00;
    strap = 2'($random(seed));
    for (k = 0; k < 8; k++) begin
      img[k] = 8'h00;
    end
    repeat (5) @(posedge clk);
    rst_b <= 1'h1;
    repeat (5) @(posedge link_clk);
    link_rst_b <= 1'h1;
    repeat (8) @(posedge link_clk);
    @(posedge clk);
    check(cfg_image === 64'h0 && {fpd, qpd} === 2'h0, "reset image");
    for (k = 0; k < 16; k++) begin
      wdat[k] = 8'($random(seed)) | 8'h20; // Keeps both powerdown fields set
    end
    xfer(1'h0, strap, 3'h6, 5'h09);
    $display("test wrap write done");
    for (k = 1; k < 4; k++) begin
      xfer(1'h0, strap ^ 2'(k), 3'h2, 5'h01);
    end
    $display("test wrong address done");
    xfer(1'h1, strap, 3'h5, 5'h04);
    $display("test wrap read done");
    wdat[0] = 8'($random(seed));
    xfer(1'h0, strap, 3'h3, 5'h01);
    xfer(1'h1, strap, 3'h3, 5'h01);
    $display("test single access done");
    // Master reset cuts a data byte short; the partial byte must not land
    wdat[0] = ~img[3];
    wr_data   <= wdat[0];
    cmd_read  <= 1'h0;
    cmd_strap <= strap;
    cmd_reg   <= 3'h3;
    cmd_len   <= 5'h01;
    cmd_valid <= 1'h1;
    @(posedge clk);
    cmd_valid <= 1'h0;
    repeat (5700) @(posedge clk);
    rst_b <= 1'h0;
    repeat (5) @(posedge clk);
    rst_b <= 1'h1;
    xfer(1'h1, strap, 3'h3, 5'h01);
    $display("test cut write done");
    // Let the watcher take the last result, then no note may be left
    @(posedge clk);
    check(rd_q.size() == 0 && img_q.size() == 0 && nack_q.size() == 0, "results missing");
    conclude();
  end
endmodule
